// ===== verilog/oms_pkg.sv
// oms_pkg: shared constants, register map and mode types of the output macrocell block.
// assumes a 32-bit apb slave decode on byte addresses with word-aligned registers.
package oms_pkg;
    localparam int OMS_CELLS = 8;
    localparam int OMS_TERMS = 8;
    localparam int OMS_ADDR_W = 8;
    // register byte offsets
    localparam logic [7:0] OMS_CTRL_OFF = 8'h00;
    localparam logic [7:0] OMS_POL_OFF = 8'h04;
    localparam logic [7:0] OMS_IOCFG_OFF = 8'h08;
    localparam logic [7:0] OMS_SIGLO_OFF = 8'h0c;
    localparam logic [7:0] OMS_SIGHI_OFF = 8'h10;
    localparam logic [7:0] OMS_STAT_OFF = 8'h14;
    // control fields
    localparam int OMS_CTRL_SYNC_BIT = 0;
    localparam int OMS_CTRL_SEL_BIT = 1;
    localparam int OMS_CTRL_RUN_BIT = 2;
    // status fields
    localparam int OMS_ST_MODE_LSB = 0;
    localparam int OMS_ST_RUN_BIT = 2;
    localparam int OMS_ST_REFUSED_BIT = 3;
    localparam int OMS_ST_REGQ_LSB = 8;
    localparam int OMS_ST_PIN_LSB = 16;
    localparam int OMS_ST_OE_LSB = 24;
    // mode codes as {global_mode_select_bit, sync_mode_bit}
    localparam logic [1:0] OMS_CODE_REGISTERED = 2'h1;
    localparam logic [1:0] OMS_CODE_COMPLEX = 2'h3;
    localparam logic [1:0] OMS_CODE_SIMPLE = 2'h2;
    // reset values
    localparam logic [1:0] OMS_MODE_RST = 2'h2;
    localparam logic [7:0] OMS_POL_RST = 8'h00;
    localparam logic [7:0] OMS_IOCFG_RST = 8'h00;
    localparam logic [63:0] OMS_SIG_RST = 64'h0;
    // fuse positions of the architecture and signature fields
    localparam int OMS_SIG_FUSE_FIRST = 2568;
    localparam int OMS_SIG_FUSE_LAST = 2631;
    localparam int OMS_SYNC_FUSE = 2704;
    localparam int OMS_SEL_FUSE = 2705;

    typedef enum logic [1:0] {OMS_REGISTERED, OMS_COMPLEX, OMS_SIMPLE} oms_mode_t;

    function automatic logic omsLegal(input logic [1:0] code);
        return (code == OMS_CODE_REGISTERED) || (code == OMS_CODE_COMPLEX) || (code == OMS_CODE_SIMPLE);
    endfunction

    function automatic oms_mode_t omsDecode(input logic [1:0] code);
        if (code == OMS_CODE_REGISTERED) begin
            return OMS_REGISTERED;
        end
        if (code == OMS_CODE_COMPLEX) begin
            return OMS_COMPLEX;
        end
        return OMS_SIMPLE;
    endfunction
endpackage

// ===== verilog/oms_cell.sv
// oms_cell: combinational datapath of one output macrocell.
// assumes product terms, the stored register bit and the shared enable pin arrive from the top.
`timescale 1ns/1ps
module oms_cell
    import oms_pkg::*;
#(
    parameter int TERMS = OMS_TERMS
) (
    input  wire oms_mode_t          mode,
    input  wire logic               polarity,
    input  wire logic               ioCfg,
    input  wire logic               isCentre,
    input  wire logic [TERMS-1:0]   terms,
    input  wire logic               regQ,
    input  wire logic               oePinN,
    output logic                    sumRaw,
    output logic                    pinVal,
    output logic                    pinEn
);
    always_comb begin
        sumRaw = |terms;
        pinVal = sumRaw ^ polarity;
        pinEn = 1'b1;
        unique case (mode)
            OMS_REGISTERED: begin
                if (ioCfg) begin
                    sumRaw = |terms[TERMS-1:1];
                    pinVal = sumRaw ^ polarity;
                    pinEn = terms[0];
                end else begin
                    pinVal = regQ ^ polarity;
                    pinEn = ~oePinN;
                end
            end
            OMS_COMPLEX: begin
                sumRaw = |terms[TERMS-1:1];
                pinVal = sumRaw ^ polarity;
                pinEn = terms[0];
            end
            OMS_SIMPLE: begin
                pinEn = ~ioCfg | isCentre;
            end
        endcase
    end
endmodule

// ===== verilog/oms_sig.sv
// oms_sig: 64-bit user signature store, written a byte lane at a time.
// assumes write strobes are single-cycle pulses from the bus slave.
`timescale 1ns/1ps
module oms_sig
    import oms_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        wrLo,
    input  wire logic        wrHi,
    input  wire logic [3:0]  strb,
    input  wire logic [31:0] wdata,
    output logic [63:0]      sig
);
    // byte 7 (bits 63:56) sits at the lowest fuse position
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sig <= OMS_SIG_RST;
        end else begin
            for (int b = 0; b < 4; b++) begin
                if (wrLo && strb[b]) begin
                    sig[8*b +: 8] <= wdata[8*b +: 8];
                end
                if (wrHi && strb[b]) begin
                    sig[32 + 8*b +: 8] <= wdata[8*b +: 8];
                end
            end
        end
    end
endmodule

// ===== verilog/output_macrocell_config.sv
// output_macrocell_config: eight configurable output macrocells with an apb register file.
// assumes apb4 master on core_clk; pins, clock pin and enable pin are synchronous inputs.
//
// Overview of operation
// - Two global bits select one of exactly three modes for all cells: simple, complex or registered.
// - Each cell has a polarity bit that inverts or passes its output in every mode.
// - Each cell has a configuration bit choosing I/O cell or the mode's dedicated output type.
// - The architecture is two global bits plus two bits per cell, eighteen in all.
// - In registered mode the clock pin is always the register clock and the enable pin the shared enable.
// - Registered cells share the common clock and enable; any cell may be register or I/O.
// - In registered mode a register sums eight terms and an I/O cell sums seven.
// - In complex mode at most six cells are I/O; the two outermost cells are output only.
// - In complex mode the clock and enable pins feed the array on the outermost cells' feedback lines.
// - In complex mode each cell sums seven terms and one more term drives its output enable.
// - In simple mode a pin is a dedicated input or an always-enabled output of eight terms.
// - In simple mode feedback comes via the adjacent pin and the centre cells are always outputs.
// - In complex and simple modes the clock and enable pins are plain array inputs.
// - A 64-bit user signature of eight bytes is held, byte 7 the most significant.
// - Registers capture their sum on the rising edge of the shared clock pin.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
module output_macrocell_config
    import oms_pkg::*;
#(
    parameter int CELLS = OMS_CELLS,
    parameter int TERMS = OMS_TERMS
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [OMS_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    input  wire logic [CELLS*TERMS-1:0] termIn,
    input  wire logic                  clkPin,
    input  wire logic                  oePinN,
    input  wire logic [CELLS-1:0]      pinIn,
    output logic [CELLS-1:0]           pinOut,
    output logic [CELLS-1:0]           pinOe,
    output logic [CELLS-1:0]           arrayFb,
    output logic [1:0]                 dedIn
);
    if (CELLS != OMS_CELLS || TERMS < 2 || TERMS > 32) begin : g_bad
        $error("unsupported CELLS or TERMS");
    end

    // architecture state
    logic              syncModeBit;
    logic              globalModeSelectBit;
    logic              run;
    logic [CELLS-1:0]  polarity;
    logic [CELLS-1:0]  cellIoConfigBit;
    logic [63:0]       userSignatureField;
    logic              refused;
    oms_mode_t         mode;

    // datapath state
    logic              clkPinQ;
    logic              clkRise;
    logic [CELLS-1:0]  regQ;
    logic [CELLS-1:0]  sumRaw;
    logic [CELLS-1:0]  cellVal;
    logic [CELLS-1:0]  cellEn;
    logic [CELLS-1:0]  next_arrayFb;
    logic [1:0]        next_dedIn;

    // bus decode
    logic              access;
    logic              done;
    logic              wrDone;
    logic              hitCtrl;
    logic              hitPol;
    logic              hitIo;
    logic              hitSigLo;
    logic              hitSigHi;
    logic              hitStat;
    logic              mapped;
    logic              staticHit;
    logic              badMode;
    logic              wrErr;
    logic              next_err;
    logic [31:0]       next_rdata;

    assign mode = omsDecode({globalModeSelectBit, syncModeBit});

    // apb slave: answer one cycle into the access phase
    assign access = psel & penable & ~pready;
    assign done = psel & penable & pready;
    assign hitCtrl = (paddr == OMS_CTRL_OFF);
    assign hitPol = (paddr == OMS_POL_OFF);
    assign hitIo = (paddr == OMS_IOCFG_OFF);
    assign hitSigLo = (paddr == OMS_SIGLO_OFF);
    assign hitSigHi = (paddr == OMS_SIGHI_OFF);
    assign hitStat = (paddr == OMS_STAT_OFF);
    assign mapped = hitCtrl | hitPol | hitIo | hitSigLo | hitSigHi | hitStat;
    assign staticHit = hitPol | hitIo | hitSigLo | hitSigHi;
    // a mode change while running is dropped, so only the run bit matters then
    assign badMode = hitCtrl & ~run & pstrb[0]
                   & ~omsLegal({pwdata[OMS_CTRL_SEL_BIT], pwdata[OMS_CTRL_SYNC_BIT]});
    assign wrErr = pwrite & ((staticHit & run) | badMode);
    assign next_err = ~mapped | wrErr;
    assign wrDone = done & pwrite & ~pslverr;

    always_comb begin
        next_rdata = 32'h0;
        unique case (1'b1)
            hitCtrl: begin
                next_rdata[OMS_CTRL_SYNC_BIT] = syncModeBit;
                next_rdata[OMS_CTRL_SEL_BIT] = globalModeSelectBit;
                next_rdata[OMS_CTRL_RUN_BIT] = run;
            end
            hitPol: next_rdata[CELLS-1:0] = polarity;
            hitIo: next_rdata[CELLS-1:0] = cellIoConfigBit;
            hitSigLo: next_rdata = userSignatureField[31:0];
            hitSigHi: next_rdata = userSignatureField[63:32];
            hitStat: begin
                next_rdata[OMS_ST_MODE_LSB +: 2] = {globalModeSelectBit, syncModeBit};
                next_rdata[OMS_ST_RUN_BIT] = run;
                next_rdata[OMS_ST_REFUSED_BIT] = refused;
                next_rdata[OMS_ST_REGQ_LSB +: CELLS] = regQ;
                next_rdata[OMS_ST_PIN_LSB +: CELLS] = pinIn;
                next_rdata[OMS_ST_OE_LSB +: CELLS] = pinOe;
            end
            default: next_rdata = 32'h0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            pready <= access;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= access & next_err;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            prdata <= 32'h0;
        end else if (access) begin
            prdata <= pwrite ? 32'h0 : next_rdata;
        end
    end

    // architecture registers, writable only while stopped except the run bit
    always_ff @(posedge core_clk) begin
        if (rst) begin
            {globalModeSelectBit, syncModeBit} <= OMS_MODE_RST;
            run <= 1'b0;
        end else if (wrDone && hitCtrl && pstrb[0]) begin
            run <= pwdata[OMS_CTRL_RUN_BIT];
            if (!run) begin
                syncModeBit <= pwdata[OMS_CTRL_SYNC_BIT];
                globalModeSelectBit <= pwdata[OMS_CTRL_SEL_BIT];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            polarity <= OMS_POL_RST;
        end else if (wrDone && hitPol && pstrb[0]) begin
            polarity <= pwdata[CELLS-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cellIoConfigBit <= OMS_IOCFG_RST;
        end else if (wrDone && hitIo && pstrb[0]) begin
            cellIoConfigBit <= pwdata[CELLS-1:0];
        end
    end

    // refused-write flag: a new refusal wins over a clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            refused <= 1'b0;
        end else if (done && pwrite && wrErr) begin
            refused <= 1'b1;
        end else if (wrDone && hitStat && pstrb[0] && pwdata[OMS_ST_REFUSED_BIT]) begin
            refused <= 1'b0;
        end
    end

    oms_sig u_sig (
        .core_clk (core_clk),
        .rst      (rst),
        .wrLo     (wrDone & hitSigLo),
        .wrHi     (wrDone & hitSigHi),
        .strb     (pstrb),
        .wdata    (pwdata),
        .sig      (userSignatureField)
    );

    // macrocell array
    for (genvar i = 0; i < CELLS; i++) begin : g_cell
        oms_cell #(
            .TERMS (TERMS)
        ) u_cell (
            .mode     (mode),
            .polarity (polarity[i]),
            .ioCfg    (cellIoConfigBit[i]),
            .isCentre ((i == CELLS/2 - 1) || (i == CELLS/2)),
            .terms    (termIn[i*TERMS +: TERMS]),
            .regQ     (regQ[i]),
            .oePinN   (oePinN),
            .sumRaw   (sumRaw[i]),
            .pinVal   (cellVal[i]),
            .pinEn    (cellEn[i])
        );
    end

    // shared clock pin edge; pins are synchronous so one stage suffices
    always_ff @(posedge core_clk) begin
        if (rst) begin
            clkPinQ <= 1'b0;
        end else begin
            clkPinQ <= clkPin;
        end
    end

    assign clkRise = clkPin & ~clkPinQ;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            regQ <= '0;
        end else if (run && mode == OMS_REGISTERED && clkRise) begin
            for (int i = 0; i < CELLS; i++) begin
                if (!cellIoConfigBit[i]) begin
                    regQ[i] <= sumRaw[i];
                end
            end
        end
    end

    // feedback routing into the array
    always_comb begin
        next_arrayFb = '0;
        next_dedIn = 2'h0;
        if (run) begin
            unique case (mode)
                OMS_REGISTERED: begin
                    for (int i = 0; i < CELLS; i++) begin
                        next_arrayFb[i] = cellIoConfigBit[i] ? pinIn[i] : regQ[i];
                    end
                end
                OMS_COMPLEX: begin
                    for (int i = 1; i < CELLS - 1; i++) begin
                        next_arrayFb[i] = cellIoConfigBit[i] & pinIn[i];
                    end
                    next_arrayFb[0] = clkPin;
                    next_arrayFb[CELLS-1] = oePinN;
                    next_dedIn = {oePinN, clkPin};
                end
                OMS_SIMPLE: begin
                    // line i reads its outward neighbour; centre pins feed no line
                    for (int i = 1; i < CELLS/2; i++) begin
                        next_arrayFb[i] = cellIoConfigBit[i-1] & pinIn[i-1];
                    end
                    for (int i = CELLS/2; i < CELLS - 1; i++) begin
                        next_arrayFb[i] = cellIoConfigBit[i+1] & pinIn[i+1];
                    end
                    next_dedIn = {oePinN, clkPin};
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            arrayFb <= '0;
            dedIn <= 2'h0;
        end else begin
            arrayFb <= next_arrayFb;
            dedIn <= next_dedIn;
        end
    end

    // pins stay released until run is set
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pinOut <= '0;
            pinOe <= '0;
        end else begin
            pinOut <= run ? cellVal : '0;
            pinOe <= run ? cellEn : '0;
        end
    end

endmodule

// ===== tb/oms_chk_sva.sv
// oms_chk_sva: port-level checks of the output macrocell block.
// assumes configuration is shadowed from completed, accepted apb writes.
`timescale 1ns/1ps
module oms_chk_sva
    import oms_pkg::*;
#(
    parameter int CELLS = OMS_CELLS,
    parameter int TERMS = OMS_TERMS
) (
    input wire logic                   core_clk,
    input wire logic                   rst,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [OMS_ADDR_W-1:0]  paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [3:0]             pstrb,
    input wire logic                   pready,
    input wire logic [31:0]            prdata,
    input wire logic                   pslverr,
    input wire logic [CELLS*TERMS-1:0] termIn,
    input wire logic                   clkPin,
    input wire logic                   oePinN,
    input wire logic [CELLS-1:0]       pinIn,
    input wire logic [CELLS-1:0]       pinOut,
    input wire logic [CELLS-1:0]       pinOe,
    input wire logic [CELLS-1:0]       arrayFb,
    input wire logic [1:0]             dedIn
);
    logic             runS;
    logic [1:0]       modeS;
    logic [CELLS-1:0] polS;
    logic [CELLS-1:0] ioS;
    logic [1:0]       age;
    logic             wrOk;
    logic             st;
    logic [CELLS-1:0] t0;
    logic [CELLS-1:0] hi;
    logic [CELLS-1:0] all;
    assign wrOk = psel && penable && pready && pwrite && !pslverr && pstrb[0];
    assign st = runS && (age == 2'h3);
    for (genvar i = 0; i < CELLS; i++) begin : g_t
        assign t0[i] = termIn[i*TERMS];
        assign hi[i] = |termIn[i*TERMS+1 +: TERMS-1];
        assign all[i] = |termIn[i*TERMS +: TERMS];
    end
    // shadow of the configuration; mode only moves while stopped
    always_ff @(posedge core_clk) begin
        if (rst) begin
            runS <= 1'b0;
            modeS <= OMS_MODE_RST;
            polS <= '0;
            ioS <= '0;
        end else if (wrOk && paddr == OMS_CTRL_OFF) begin
            runS <= pwdata[OMS_CTRL_RUN_BIT];
            if (!runS) begin
                modeS <= pwdata[1:0];
            end
        end else if (wrOk && paddr == OMS_POL_OFF) begin
            polS <= pwdata[CELLS-1:0];
        end else if (wrOk && paddr == OMS_IOCFG_OFF) begin
            ioS <= pwdata[CELLS-1:0];
        end
    end
    // cycles since run last changed, so pipeline lag is settled
    always_ff @(posedge core_clk) begin
        if (rst || (wrOk && paddr == OMS_CTRL_OFF && pwdata[OMS_CTRL_RUN_BIT] != runS)) begin
            age <= 2'h0;
        end else if (age != 2'h3) begin
            age <= age + 2'h1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_stopped_quiet: assert property (!runS && age == 2'h3 |-> {pinOut, pinOe, arrayFb, dedIn} == '0)
        else $error("outputs active while stopped");
    a_reg_no_ded: assert property (st && modeS == OMS_CODE_REGISTERED |-> dedIn == 2'h0)
        else $error("clock or enable pin used as data in registered mode");
    a_reg_shared_oe: assert property (st && modeS == OMS_CODE_REGISTERED
        |-> (pinOe & ~ioS) == ({CELLS{~$past(oePinN)}} & ~ioS)) else $error("register enable not shared pin");
    a_reg_io_sum: assert property (st && modeS == OMS_CODE_REGISTERED
        |-> ((pinOut ^ polS) & ioS) == ($past(hi) & ioS)) else $error("registered mode io sum wrong");
    a_reg_capture: assert property (st && modeS == OMS_CODE_REGISTERED && $rose(clkPin)
        |-> ##2 ((pinOut ^ polS) & ~ioS) == ($past(all, 2) & ~ioS)) else $error("register capture wrong");
    a_cplx_terms: assert property (st && modeS == OMS_CODE_COMPLEX
        |-> pinOe == $past(t0) && (pinOut ^ polS) == $past(hi)) else $error("complex sum or enable wrong");
    a_cplx_outer_fb: assert property (st && modeS == OMS_CODE_COMPLEX
        |-> arrayFb[0] == $past(clkPin) && arrayFb[CELLS-1] == $past(oePinN)) else $error("outer feedback wrong");
    a_ded_inputs: assert property (st && modeS != OMS_CODE_REGISTERED
        |-> dedIn == {$past(oePinN), $past(clkPin)}) else $error("dedicated inputs wrong");
    a_simple_oe: assert property (st && modeS == OMS_CODE_SIMPLE
        |-> pinOe == ~(ioS & 8'he7) && ((pinOut ^ polS) & pinOe) == ($past(all) & pinOe))
        else $error("simple output wrong");
    a_simple_fb: assert property (st && modeS == OMS_CODE_SIMPLE |-> arrayFb[0] == 1'b0 && arrayFb[7] == 1'b0
        && arrayFb[1] == ($past(pinIn[0]) & ioS[0]) && arrayFb[6] == ($past(pinIn[7]) & ioS[7]))
        else $error("simple feedback wrong");
endmodule

bind output_macrocell_config oms_chk_sva #(.CELLS(CELLS), .TERMS(TERMS)) u_chk (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr), .termIn(termIn),
    .clkPin(clkPin), .oePinN(oePinN), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .arrayFb(arrayFb),
    .dedIn(dedIn));

// ===== tb/oms_board.sv
// oms_board: board logic around the macrocells: terms, clock pin, enable pin, pin wires.
// assumes the pins carry pull-ups and the bench never drives a pin the block drives.
`timescale 1ns/1ps
module oms_board (
    input  wire logic        core_clk,
    input  wire logic [63:0] termSet,
    input  wire logic [7:0]  drvEn,
    input  wire logic [7:0]  drvVal,
    input  wire logic        oeSetN,
    input  wire logic        clkReq,
    input  wire logic [7:0]  pinOut,
    input  wire logic [7:0]  pinOe,
    output logic [63:0]      termIn,
    output logic             clkPin,
    output logic             oePinN,
    output logic [7:0]       pinIn
);
    logic [1:0] clkCnt;
    initial begin
        termIn = '0;
        oePinN = 1'b0;
        clkCnt = 2'h0;
    end
    // terms move only while the clock pin is low, so set-up is met at each rise
    always @(posedge core_clk) begin
        if (!clkPin) begin
            termIn <= termSet;
        end
        oePinN <= oeSetN;
    end
    // one low set-up cycle, then the clock pin is high for two cycles
    always @(posedge core_clk) begin
        if (clkReq && clkCnt == 2'h0) begin
            clkCnt <= 2'h3;
        end else if (clkCnt != 2'h0) begin
            clkCnt <= clkCnt - 2'h1;
        end
    end
    assign clkPin = (clkCnt == 2'h2) || (clkCnt == 2'h1);
    assign pinIn = (pinOe & pinOut) | (~pinOe & drvEn & drvVal) | (~pinOe & ~drvEn);
endmodule

// ===== tb/tb_output_macrocell_config.sv
// tb_output_macrocell_config: apb sequences checking registers and pins in each mode.
// assumes the checker is bound to the design and the board model drives the array inputs.
`timescale 1ns/1ps
module tb_output_macrocell_config
    import oms_pkg::*;
;
    localparam logic [63:0] PAT = 64'h0380000101000201;
    localparam logic [7:0]  POLV = 8'h5a;
    localparam logic [23:0] IOS = 24'h817e0f;
    localparam logic [5:0]  CODES = {OMS_CODE_SIMPLE, OMS_CODE_COMPLEX, OMS_CODE_REGISTERED};
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    logic [63:0] termSet = PAT;
    logic [7:0]  drvEn = 8'h00;
    logic        oeSetN = 1'b0;
    logic        clkReq = 1'b0;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [63:0] termIn;
    logic        clkPin;
    logic        oePinN;
    logic [7:0]  pinIn;
    logic [7:0]  pinOut;
    logic [7:0]  pinOe;
    logic [7:0]  arrayFb;
    logic [1:0]  dedIn;
    int          errCount = 0;
    int          testsRun = 0;
    int          cyc = 0;
    logic [31:0] rdv;
    logic        rde;
    always #5 core_clk = ~core_clk;
    output_macrocell_config dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .termIn(termIn), .clkPin(clkPin), .oePinN(oePinN), .pinIn(pinIn),
        .pinOut(pinOut), .pinOe(pinOe), .arrayFb(arrayFb), .dedIn(dedIn));
    oms_board u_board (.core_clk(core_clk), .termSet(termSet), .drvEn(drvEn), .drvVal(8'h00),
        .oeSetN(oeSetN), .clkReq(clkReq), .pinOut(pinOut), .pinOe(pinOe), .termIn(termIn),
        .clkPin(clkPin), .oePinN(oePinN), .pinIn(pinIn));
    task automatic testDone();
        $display("comparisons %0d mismatches %0d", testsRun, errCount);
        if (errCount == 0 && testsRun > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        testsRun++;
        if (g !== e) begin
            errCount++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] r, output logic e);
        int n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic x);
        apb(1'b1, a, d, s, rdv, rde);
        chk32("pslverr", {31'h0, x}, {31'h0, rde});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic x);
        apb(1'b0, a, 32'h0, 4'h0, rdv, rde);
        chk32("prdata", v, rdv);
        chk32("pslverr", {31'h0, x}, {31'h0, rde});
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errCount++;
            testDone();
        end
    end
    initial begin
        logic [7:0] eAll;
        logic [7:0] eHi;
        logic [7:0] eT0;
        logic [7:0] io;
        logic [7:0] expOut;
        logic [7:0] expOe;
        for (int i = 0; i < 8; i++) begin
            eAll[i] = |PAT[i*8 +: 8];
            eHi[i] = |PAT[i*8+1 +: 7];
            eT0[i] = PAT[i*8];
        end
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        rd(OMS_CTRL_OFF, 32'h2, 1'b0);
        rd(OMS_POL_OFF, 32'h0, 1'b0);
        rd(OMS_IOCFG_OFF, 32'h0, 1'b0);
        rd(OMS_STAT_OFF, 32'h00ff0002, 1'b0);
        rd(8'h18, 32'h0, 1'b1);
        wr(OMS_SIGHI_OFF, 32'h88776655, 4'hf, 1'b0);
        wr(OMS_SIGLO_OFF, 32'h44332211, 4'hf, 1'b0);
        wr(OMS_SIGHI_OFF, 32'haa000000, 4'h8, 1'b0);
        rd(OMS_SIGHI_OFF, 32'haa776655, 1'b0);
        rd(OMS_SIGLO_OFF, 32'h44332211, 1'b0);
        wr(OMS_CTRL_OFF, 32'h4, 4'h1, 1'b1);
        rd(OMS_STAT_OFF, 32'h00ff000a, 1'b0);
        wr(OMS_STAT_OFF, 32'h8, 4'h1, 1'b0);
        rd(OMS_STAT_OFF, 32'h00ff0002, 1'b0);
        for (int m = 0; m < 3; m++) begin
            io = IOS[m*8 +: 8];
            expOe = (m == 0) ? (~io | (eT0 & io)) : (m == 1) ? eT0 : ~(io & 8'he7);
            expOut = ((m == 0) ? ((eAll & ~io) | (eHi & io)) : (m == 1) ? eHi : eAll) ^ POLV;
            drvEn <= ~expOe & 8'h81;
            wr(OMS_POL_OFF, {24'h0, POLV}, 4'h1, 1'b0);
            wr(OMS_IOCFG_OFF, {24'h0, io}, 4'h1, 1'b0);
            wr(OMS_CTRL_OFF, {30'h1, CODES[m*2 +: 2]}, 4'h1, 1'b0);
            wr(OMS_POL_OFF, 32'h0, 4'h1, 1'b1);
            rd(OMS_POL_OFF, {24'h0, POLV}, 1'b0);
            rd(OMS_CTRL_OFF, {30'h1, CODES[m*2 +: 2]}, 1'b0);
            clkReq <= 1'b1;
            @(posedge core_clk);
            clkReq <= 1'b0;
            repeat (6) @(posedge core_clk);
            chk32("pinOe", {24'h0, expOe}, {24'h0, pinOe});
            chk32("pinOut", {24'h0, expOut & expOe}, {24'h0, pinOut & expOe});
            oeSetN <= 1'b1;
            repeat (3) @(posedge core_clk);
            chk32("dedIn", (m == 0) ? 32'h0 : 32'h2, {30'h0, dedIn});
            chk32("pinOe off", {24'h0, (m == 0) ? (eT0 & io) : expOe}, {24'h0, pinOe});
            oeSetN <= 1'b0;
            wr(OMS_CTRL_OFF, 32'h0, 4'h1, 1'b0);
            rd(OMS_CTRL_OFF, {30'h0, CODES[m*2 +: 2]}, 1'b0);
            wr(OMS_STAT_OFF, 32'h8, 4'h1, 1'b0);
        end
        testDone();
    end
endmodule
